//--- verilog/tfpwm_top.sv
// 8-bit timer with fast and dual-slope pwm, two compare outputs, avalon-mm registers
//
// Notes on behaviour
// (R01) modes 3 and 7 count single slope
// (R02) fast top is 0xFF or channel a compare
// (R03) non-inverting fast: clear on match, set at bottom
// (R04) inverting fast: set on match, clear at bottom
// (R05) fast counter clears the cycle after top
// (R06) fast overflow flag set at top
// (R07) field two non-inverted, three inverted
// (R08) pin shows output only when direction is output
// (R09) fast extremes: bottom spike, max constant level
// (R10) fast field one toggles on match
// (R11) compare values double buffered in pwm modes
// (R12) modes 1 and 5 count up then down
// (R13) dual-slope top is 0xFF or channel a compare
// (R14) dual-slope: clear up-match, set down-match, or inverse
// (R15) dual-slope reverses at top, holds one cycle
// (R16) dual-slope overflow flag set at bottom
// (R17) dual-slope extremes give constant levels
// (R18) leaving max forces up-match level at bottom
// (R19) missed up-match transition made at bottom
// (R20) timer clock is prescaled i/o clock
// (R21) fast period 256 timer cycles at top 0xFF
// (R22) dual-slope period 510 timer cycles at top 0xFF
// (R23) compare equal top: act at top instead
// (R24) channel a field one toggles only with top bit
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tfpwm_top
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_oc_a,
    output logic             o_oc_a_oe,
    output logic             o_oc_b,
    output logic             o_oc_b_oe,
    output logic             o_overflow
);
    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [7:0]            ctrl_a_q;
    logic [7:0]            ctrl_b_q;
    logic [7:0]            count_q;
    logic [7:0]            count_d;
    logic [7:0]            cmp_a_buf_q;
    logic [7:0]            cmp_b_buf_q;
    logic [7:0]            cmp_a_q;
    logic [7:0]            cmp_b_q;
    logic [1:0]            pin_dir_q;
    logic                  ovf_q;
    logic                  block_q;
    tfpwm_pkg::tfpwm_dir_e dir_q;
    tfpwm_pkg::tfpwm_dir_e dir_d;
    logic [31:0]           rdata_d;

    // ---------------------------------------------------------------
    // decode of the control fields
    // ---------------------------------------------------------------
    logic [2:0]             wgm;
    logic [1:0]             com_a;
    logic [1:0]             com_b;
    logic [2:0]             clk_sel;
    logic                   mode_fast;
    logic                   mode_phase;
    logic                   mode_pwm;
    logic [7:0]             top;
    logic                   at_top;
    logic                   at_bot;
    tfpwm_pkg::tfpwm_mode_s mode;
    logic                   tick;
    logic                   level_a;
    logic                   level_b;
    logic                   link_a;
    logic                   link_b;

    assign wgm        = {ctrl_b_q[tfpwm_pkg::POS_WGM_TOP], ctrl_a_q[tfpwm_pkg::POS_WGM_LO +: 2]};
    assign com_a      = ctrl_a_q[tfpwm_pkg::POS_COM_A +: 2];
    assign com_b      = ctrl_a_q[tfpwm_pkg::POS_COM_B +: 2];
    assign clk_sel    = ctrl_b_q[tfpwm_pkg::POS_CLK_SEL +: 3];
    assign mode_fast  = tfpwm_pkg::is_fast(wgm);   // R01
    assign mode_phase = tfpwm_pkg::is_phase(wgm);  // R12
    assign mode_pwm   = mode_fast || mode_phase;
    assign mode       = '{fast: mode_fast, phase: mode_phase, top_bit: wgm[2]};

    // in pwm modes, top is the channel a compare value when the top bit is set
    assign top    = (mode_pwm && wgm[2]) ? cmp_a_q : tfpwm_pkg::CNT_MAX;  // R02 R13
    assign at_top = (count_q == top);
    assign at_bot = (count_q == tfpwm_pkg::CNT_BOTTOM);

    // in pwm modes, field value one on channel b is reserved and leaves the pin alone
    assign link_a = (com_a != tfpwm_pkg::COM_OFF) &&
                    !(mode_pwm && com_a == tfpwm_pkg::COM_TOGGLE && !wgm[2]);  // R24
    assign link_b = (com_b != tfpwm_pkg::COM_OFF) &&
                    !(mode_pwm && com_b == tfpwm_pkg::COM_TOGGLE);

    // ---------------------------------------------------------------
    // avalon-mm slave handshake
    // ---------------------------------------------------------------
    logic req;
    logic acc;
    logic wr_en;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_count;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_flags;
    logic wr_dir;
    logic [7:0] wbyte;

    // each access waits exactly one cycle; the second cycle completes it
    assign req   = i_avs_read || i_avs_write;
    assign acc   = req && !o_avs_waitrequest;
    assign wr_en = acc && i_avs_write && i_avs_byteenable[0];
    assign wbyte = i_avs_writedata[7:0];

    assign wr_ctrl_a = wr_en && (i_avs_address == tfpwm_pkg::OFS_CTRL_A);
    assign wr_ctrl_b = wr_en && (i_avs_address == tfpwm_pkg::OFS_CTRL_B);
    assign wr_count  = wr_en && (i_avs_address == tfpwm_pkg::OFS_COUNT);
    assign wr_cmp_a  = wr_en && (i_avs_address == tfpwm_pkg::OFS_CMP_A);
    assign wr_cmp_b  = wr_en && (i_avs_address == tfpwm_pkg::OFS_CMP_B);
    assign wr_flags  = wr_en && (i_avs_address == tfpwm_pkg::OFS_FLAGS);
    assign wr_dir    = wr_en && (i_avs_address == tfpwm_pkg::OFS_PIN_DIR);

    // read mux; the cpu sees the compare buffers, unmapped reads give zero
    always_comb
    begin
        rdata_d = tfpwm_pkg::RD_ZERO;
        unique case (i_avs_address)
            tfpwm_pkg::OFS_CTRL_A:  rdata_d[7:0] = ctrl_a_q;
            tfpwm_pkg::OFS_CTRL_B:  rdata_d[7:0] = ctrl_b_q;
            tfpwm_pkg::OFS_COUNT:   rdata_d[7:0] = count_q;
            tfpwm_pkg::OFS_CMP_A:   rdata_d[7:0] = cmp_a_buf_q;
            tfpwm_pkg::OFS_CMP_B:   rdata_d[7:0] = cmp_b_buf_q;
            tfpwm_pkg::OFS_FLAGS:
            begin
                rdata_d[tfpwm_pkg::POS_OVF]  = ovf_q;
                rdata_d[tfpwm_pkg::POS_DOWN] = (dir_q == tfpwm_pkg::TFPWM_DOWN);
            end
            tfpwm_pkg::OFS_PIN_DIR: rdata_d[1:0] = pin_dir_q;
            default:                rdata_d = tfpwm_pkg::RD_ZERO;
        endcase
    end

    // waitrequest idles high and drops for one cycle per request
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= tfpwm_pkg::RD_ZERO;
        end
        else
        begin
            o_avs_waitrequest <= !(req && o_avs_waitrequest);
            if (req && o_avs_waitrequest)
                o_avs_readdata <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // output mode fields act at once; only compare values are buffered
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_a_q  <= tfpwm_pkg::RST_BYTE;
            ctrl_b_q  <= tfpwm_pkg::RST_BYTE;
            pin_dir_q <= 2'h0;
        end
        else
        begin
            if (wr_ctrl_a)
                ctrl_a_q <= wbyte & 8'hF3;  // bits 3:2 read as zero
            if (wr_ctrl_b)
                ctrl_b_q <= wbyte & 8'h0F;
            if (wr_dir)
                pin_dir_q <= wbyte[1:0];
        end
    end

    // ---------------------------------------------------------------
    // timer clock
    // ---------------------------------------------------------------
    tfpwm_prescale u_prescale
    (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_sel  (clk_sel),
        .o_tick (tick)
    );

    // ---------------------------------------------------------------
    // compare values and their buffers
    // ---------------------------------------------------------------
    logic load_cmp;

    // in pwm modes the active values reload only as the counter leaves top,
    // so a fast period never sees a half-applied duty, while a dual-slope period
    // changes value at its top; other modes write through
    assign load_cmp = !mode_pwm || (tick && at_top);  // R11

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cmp_a_buf_q <= tfpwm_pkg::RST_BYTE;
            cmp_b_buf_q <= tfpwm_pkg::RST_BYTE;
            cmp_a_q     <= tfpwm_pkg::RST_BYTE;
            cmp_b_q     <= tfpwm_pkg::RST_BYTE;
        end
        else
        begin
            if (wr_cmp_a)
                cmp_a_buf_q <= wbyte;
            if (wr_cmp_b)
                cmp_b_buf_q <= wbyte;
            if (load_cmp)
            begin
                cmp_a_q <= wr_cmp_a ? wbyte : cmp_a_buf_q;  // R11
                cmp_b_q <= wr_cmp_b ? wbyte : cmp_b_buf_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // counter sequencing
    // ---------------------------------------------------------------
    // next count and direction on a timer tick
    always_comb
    begin
        count_d = count_q;
        dir_d   = dir_q;
        if (mode_fast)
        begin
            dir_d   = tfpwm_pkg::TFPWM_UP;
            count_d = at_top ? tfpwm_pkg::CNT_BOTTOM : 8'(count_q + 8'h01);  // R05 R21
        end
        else if (mode_phase)
        begin
            if (dir_q == tfpwm_pkg::TFPWM_UP)
            begin
                if (at_top && !at_bot)
                begin
                    dir_d   = tfpwm_pkg::TFPWM_DOWN;   // R15 R22
                    count_d = 8'(count_q - 8'h01);
                end
                else if (!at_top)
                    count_d = 8'(count_q + 8'h01);
            end
            else
            begin
                if (at_bot)
                begin
                    dir_d   = tfpwm_pkg::TFPWM_UP;     // R12
                    count_d = at_top ? count_q : 8'(count_q + 8'h01);
                end
                else
                    count_d = 8'(count_q - 8'h01);
            end
        end
        else
        begin
            dir_d   = tfpwm_pkg::TFPWM_UP;
            count_d = 8'(count_q + 8'h01);  // plain wrap outside the pwm modes
        end
    end

    // a software write to the counter wins over the tick and masks the
    // next timer cycle's match so the written value does not fire at once
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            count_q <= tfpwm_pkg::CNT_BOTTOM;
            dir_q   <= tfpwm_pkg::TFPWM_UP;
            block_q <= 1'b0;
        end
        else
        begin
            if (wr_count)
                count_q <= wbyte;
            else if (tick)
            begin
                count_q <= count_d;
                dir_q   <= dir_d;
            end
            if (wr_count)
                block_q <= 1'b1;
            else if (tick)
                block_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // overflow flag
    // ---------------------------------------------------------------
    logic ovf_fast;
    logic ovf_phase;
    logic ovf_set;
    logic ovf_clr;

    // fast sets on arrival at top, dual-slope on arrival at bottom
    assign ovf_fast  = mode_fast && tick && !wr_count && !at_top && (count_d == top);  // R06
    assign ovf_phase = mode_phase && tick && !wr_count && !at_bot &&
                       (count_d == tfpwm_pkg::CNT_BOTTOM);                           // R16
    assign ovf_set   = ovf_fast || ovf_phase;
    assign ovf_clr   = wr_flags && wbyte[tfpwm_pkg::POS_OVF];

    // a set in the same cycle as a write-one clear wins
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ovf_q <= 1'b0;
        else if (ovf_set)
            ovf_q <= 1'b1;
        else if (ovf_clr)
            ovf_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // compare output units
    // ---------------------------------------------------------------
    tfpwm_out_unit u_out_a
    (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_tick   (tick),
        .i_block  (block_q),
        .i_mode   (mode),
        .i_chan_a (1'b1),
        .i_com    (com_a),
        .i_count  (count_q),
        .i_cmp    (cmp_a_q),
        .i_top    (top),
        .i_dir    (dir_q),
        .o_level  (level_a)
    );

    tfpwm_out_unit u_out_b
    (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_tick   (tick),
        .i_block  (block_q),
        .i_mode   (mode),
        .i_chan_a (1'b0),
        .i_com    (com_b),
        .i_count  (count_q),
        .i_cmp    (cmp_b_q),
        .i_top    (top),
        .i_dir    (dir_q),
        .o_level  (level_b)
    );

    // ---------------------------------------------------------------
    // pin stage
    // ---------------------------------------------------------------
    // the driver turns on only when the unit owns the pin and the direction
    // bit says output; the level is kept even while the pin is released
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_oc_a     <= 1'b0;
            o_oc_b     <= 1'b0;
            o_oc_a_oe  <= 1'b0;
            o_oc_b_oe  <= 1'b0;
            o_overflow <= 1'b0;
        end
        else
        begin
            o_oc_a     <= level_a;
            o_oc_b     <= level_b;
            o_oc_a_oe  <= link_a && pin_dir_q[tfpwm_pkg::POS_DIR_A];  // R08
            o_oc_b_oe  <= link_b && pin_dir_q[tfpwm_pkg::POS_DIR_B];  // R08
            o_overflow <= ovf_q;
        end
    end
endmodule
`default_nettype wire

//--- verilog/tfpwm_pkg.sv
// constants, types and decode helpers shared by the fast and dual-slope pwm timer
package tfpwm_pkg;

    // ---------------------------------------------------------------
    // register byte offsets on the avalon-mm slave
    // ---------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL_A  = 5'h00;
    localparam logic [4:0] OFS_CTRL_B  = 5'h04;
    localparam logic [4:0] OFS_COUNT   = 5'h08;
    localparam logic [4:0] OFS_CMP_A   = 5'h0C;
    localparam logic [4:0] OFS_CMP_B   = 5'h10;
    localparam logic [4:0] OFS_FLAGS   = 5'h14;
    localparam logic [4:0] OFS_PIN_DIR = 5'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int POS_COM_A    = 6;  // ctrl_a [7:6]
    localparam int POS_COM_B    = 4;  // ctrl_a [5:4]
    localparam int POS_WGM_LO   = 0;  // ctrl_a [1:0]
    localparam int POS_WGM_TOP  = 3;  // ctrl_b [3]
    localparam int POS_CLK_SEL  = 0;  // ctrl_b [2:0]
    localparam int POS_OVF      = 0;  // flags [0], write one to clear
    localparam int POS_DOWN     = 1;  // flags [1], read only
    localparam int POS_DIR_A    = 0;  // pin_dir [0]
    localparam int POS_DIR_B    = 1;  // pin_dir [1]

    // ---------------------------------------------------------------
    // values after reset and fixed counts
    // ---------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [7:0]  CNT_BOTTOM = 8'h00;
    localparam logic [7:0]  CNT_MAX    = 8'hFF;
    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

    // prescaler masks: divide by 1, 8, 32, 64, 128, 256, 1024
    localparam logic [9:0] DIV_1    = 10'h000;
    localparam logic [9:0] DIV_8    = 10'h007;
    localparam logic [9:0] DIV_32   = 10'h01F;
    localparam logic [9:0] DIV_64   = 10'h03F;
    localparam logic [9:0] DIV_128  = 10'h07F;
    localparam logic [9:0] DIV_256  = 10'h0FF;
    localparam logic [9:0] DIV_1024 = 10'h3FF;

    // waveform modes that concern this block
    localparam logic [2:0] WGM_PC_MAX   = 3'h1;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMP   = 3'h5;
    localparam logic [2:0] WGM_FAST_CMP = 3'h7;

    // compare output mode field values
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;

    typedef enum logic {TFPWM_UP, TFPWM_DOWN} tfpwm_dir_e;

    // mode as seen by one compare output unit
    typedef struct packed {
        logic       fast;
        logic       phase;
        logic       top_bit;
    } tfpwm_mode_s;

    function automatic logic is_fast(input logic [2:0] wgm);
        is_fast = (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_CMP);
    endfunction

    function automatic logic is_phase(input logic [2:0] wgm);
        is_phase = (wgm == WGM_PC_MAX) || (wgm == WGM_PC_CMP);
    endfunction

endpackage

//--- verilog/tfpwm_prescale.sv
// timer clock enable: divides the i/o clock by the selected prescale factor
`timescale 1ns/10ps
`default_nettype none
module tfpwm_prescale
(
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic [2:0] i_sel,
    output logic            o_tick
);
    logic [9:0] div_q;
    logic [9:0] mask;
    logic       run;

    // select zero stops the timer; the others pick a power-of-two mask
    always_comb
    begin
        unique case (i_sel)
            3'h1:    mask = tfpwm_pkg::DIV_1;
            3'h2:    mask = tfpwm_pkg::DIV_8;
            3'h3:    mask = tfpwm_pkg::DIV_32;
            3'h4:    mask = tfpwm_pkg::DIV_64;
            3'h5:    mask = tfpwm_pkg::DIV_128;
            3'h6:    mask = tfpwm_pkg::DIV_256;
            3'h7:    mask = tfpwm_pkg::DIV_1024;
            default: mask = tfpwm_pkg::DIV_1;
        endcase
    end
    assign run = (i_sel != 3'h0);

    // free counter; a stopped timer restarts its division from zero
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_q  <= 10'h000;
            o_tick <= 1'b0;
        end
        else
        begin
            div_q  <= run ? 10'(div_q + 10'h001) : 10'h000;
            o_tick <= run && ((div_q & mask) == mask);  // R20
        end
    end
endmodule
`default_nettype wire

//--- verilog/tfpwm_out_unit.sv
// one compare output unit: keeps the compare output level for a channel
`timescale 1ns/10ps
`default_nettype none
module tfpwm_out_unit
(
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_tick,
    input  wire logic                  i_block,
    input  wire tfpwm_pkg::tfpwm_mode_s i_mode,
    input  wire logic                  i_chan_a,
    input  wire logic [1:0]            i_com,
    input  wire logic [7:0]            i_count,
    input  wire logic [7:0]            i_cmp,
    input  wire logic [7:0]            i_top,
    input  wire tfpwm_pkg::tfpwm_dir_e i_dir,
    output logic                       o_level
);
    logic level_d;
    logic up_seen_q;
    logic up_seen_d;
    logic at_top;
    logic at_bot;
    logic match;
    logic special;
    logic tog_ok;
    logic going_down;

    // match decode; a counter write masks matches for one timer cycle
    assign at_top     = (i_count == i_top);
    assign at_bot     = (i_count == tfpwm_pkg::CNT_BOTTOM);
    assign match      = i_tick && !i_block && (i_count == i_cmp);
    assign special    = i_com[1] && (i_cmp == i_top);                          // R23
    assign tog_ok     = (i_com == tfpwm_pkg::COM_TOGGLE) && i_mode.top_bit && i_chan_a; // R24
    assign going_down = (i_dir == tfpwm_pkg::TFPWM_DOWN) && !at_bot;

    // next level: com[0] is the level left by a match while counting up
    always_comb
    begin
        level_d   = o_level;
        up_seen_d = up_seen_q;
        if (i_mode.fast)
        begin
            if (i_tick && at_top && i_com[1])
                level_d = ~i_com[0];                       // R03 R04 R23
            else if (match && i_com[1] && !special)
                level_d = i_com[0];                        // R03 R04 R07 R09
            else if (match && tog_ok)
                level_d = ~o_level;                        // R10
        end
        else if (i_mode.phase)
        begin
            if (i_tick && at_bot)
                up_seen_d = 1'b0;
            if (i_tick && at_bot && i_com[1] && !up_seen_q && !special)
                level_d = i_com[0];                        // R18 R19
            if (i_tick && at_top && special)
                level_d = ~i_com[0];                       // R17 R23
            else if (match && i_com[1] && !special)
            begin
                level_d = going_down ? ~i_com[0] : i_com[0];  // R14 R07
                if (!going_down)
                    up_seen_d = 1'b1;
            end
            else if (match && tog_ok)
                level_d = ~o_level;                        // R24
        end
    end

    // the level keeps its value across mode changes
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_level   <= 1'b0;
            up_seen_q <= 1'b0;
        end
        else
        begin
            o_level   <= level_d;
            up_seen_q <= up_seen_d;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tfpwm_sva.sv
// port checks for tfpwm_top
`timescale 1ns/10ps
`default_nettype none
module tfpwm_sva
(
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_oc_a,
    input wire logic        o_oc_a_oe,
    input wire logic        o_overflow
);
    // ----------------------------------------
    // bus and pin checks, all idle in reset
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    ack_next_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered");
    wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low too long");
    wait_cause_a: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
        else $error("answer without request");
    idle_wait_a: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("answer while idle");
    rd_upper_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rst_vals_a: assert property ($rose(i_nrst) |-> o_avs_waitrequest && !o_oc_a && !o_oc_a_oe && !o_overflow)
        else $error("bad value after reset");
    oe_cause_a: assert property ($changed(o_oc_a_oe) |-> $past(i_avs_write) || $past(i_avs_write, 2))
        else $error("pin enable moved alone");
    ovf_clr_a: assert property ($fell(o_overflow) |-> $past(i_avs_write) || $past(i_avs_write, 2))
        else $error("flag dropped alone");
endmodule
bind tfpwm_top tfpwm_sva tfpwm_sva_i (.i_clk, .i_nrst, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .o_oc_a, .o_oc_a_oe, .o_overflow);
`default_nettype wire

//--- testbench/tfpwm_load.sv
// external load on channel a: pin with pull-down, counts high cycles
`timescale 1ns/10ps
`default_nettype none
module tfpwm_load
(
    input  wire logic i_clk,
    input  wire logic i_clr,
    input  wire logic i_oc,
    input  wire logic i_oe,
    output var int    o_high
);
    // a released pin falls to the pull-down, never keeps the last level
    wire logic pin = i_oe ? i_oc : 1'b0;
    always_ff @(posedge i_clk)
        o_high <= i_clr ? 0 : o_high + int'(pin === 1'b1);
endmodule
`default_nettype wire

//--- testbench/tfpwm_tb_top.sv
// testbench for tfpwm_top: bus tasks, duty model, pwm scenarios
`timescale 1ns/10ps
`default_nettype none
module tfpwm_tb_top;
    logic        i_clk, i_nrst, rd, wr, clr, wq, oa, oae, ovf, ob, obe;
    logic [4:0]  adr;
    logic [31:0] wd, rdata, q;
    int          mismatches, n_checks, hi, c;
    tfpwm_top tfpwm_top_i (.i_clk, .i_nrst, .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
        .o_oc_a(oa), .o_oc_a_oe(oae), .o_oc_b(ob), .o_oc_b_oe(obe), .o_overflow(ovf));
    tfpwm_load tfpwm_load_i (.i_clk, .i_clr(clr), .i_oc(oa), .i_oe(oae), .o_high(hi));
    // ----------------------------------------
    // clock, checks and bus
    // ----------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        n = 0;
        do @(posedge i_clk); while (wq !== 1'b0 && ++n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wq !== 1'b0)
        begin
            mismatches++;
            conclude();
        end
    endtask
    // integer model: high cycles of one output period, in i/o clocks
    task automatic run(input int m, input int f, input int cv, input int dir, input int s);
        int p, e, k;
        k = (s == 2) ? 8 : 1;
        e = ((m & 3) == 3) ? cv + 1 : 2 * cv;
        p = (f == 1) ? 2 * e : ((m & 3) == 3) ? 256 : 510;
        e = (f == 3) ? p - e : e;
        e = dir * e * k;
        p = p * k;
        bus(1'b1, tfpwm_pkg::OFS_CMP_A, cv);
        bus(1'b1, tfpwm_pkg::OFS_CTRL_B, ((m >> 2) << tfpwm_pkg::POS_WGM_TOP) | s);
        bus(1'b1, tfpwm_pkg::OFS_CTRL_A, (f << tfpwm_pkg::POS_COM_A) | (m & 3));
        bus(1'b1, tfpwm_pkg::OFS_PIN_DIR, dir * 3);
        bus(1'b1, tfpwm_pkg::OFS_FLAGS, 1);
        // a new top may leave the counter above it, so allow one full wrap first
        repeat (2 * p + 256 * k + 8) @(posedge i_clk);
        @(posedge i_clk) clr <= 1'b1;
        @(posedge i_clk) clr <= 1'b0;
        repeat (p) @(posedge i_clk);
        #1 check("high cycles", e, hi);
        check("channel b pin", 0, {ob, obe});
        bus(1'b0, tfpwm_pkg::OFS_FLAGS, 0);
        check("overflow flag", 1, q & 1);
        $display("test mode %0d field %0d cmp %0d done", m, f, cv);
    endtask
    initial
    begin
        #500000;
        mismatches++;
        conclude();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {i_nrst, rd, wr, clr, adr, wd, mismatches, n_checks} = '0;
        void'($urandom(19));
        repeat (16) @(posedge i_clk);
        i_nrst <= 1'b1;
        bus(1'b1, 5'h1C, 32'hFF);
        for (int a = 0; a < 32; a += 4)
        begin
            bus(1'b0, a[4:0], 0);
            check("reset or unmapped read", 0, q);
        end
        c = $urandom_range(4, 60);
        run(3, 2, 4 * c, 1, 1);
        run(3, 3, 4 * c, 1, 1);
        run(3, 2, 0, 1, 1);
        run(3, 2, 255, 1, 1);
        run(3, 2, 4 * c, 0, 1);
        run(3, 2, c, 1, 2);
        run(7, 1, c, 1, 1);
        run(1, 2, 4 * c, 1, 1);
        run(1, 3, 4 * c, 1, 1);
        run(1, 2, 0, 1, 1);
        run(1, 2, 255, 1, 1);
        run(5, 1, c, 1, 1);
        conclude();
    end
endmodule
`default_nettype wire
